// ==== adc_alert_host.sv ====
/* bus host model: drives scl, pulls sda low.
   assumes the bench builds the pulled-up sda wire. */
`timescale 1ns/1ps
module adc_alert_host
  import adc_alert_pkg::*;
(
  input  wire logic        clk,      // clock
  input  wire logic        sda,      // wire level
  output logic             scl,      // bus clock
  output logic             sda_pull, // pulls sda low
  output logic             rd_valid, // word read pulse
  output logic [15:0]      rd_word   // word read
);
  logic nak = 1'b0;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_word = 16'h0000;
  end
  // start, repeated start and stop; six-cycle phases beat the 4-cycle minimum
  task automatic cond(input logic pre, input logic post, input logic fin);
    repeat (3) @(posedge clk);
    sda_pull <= pre;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (6) @(posedge clk);
    sda_pull <= post;
    repeat (6) @(posedge clk);
    scl <= fin;
  endtask
  // data changes only mid-low so it never looks like start or stop
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge clk);
    sda_pull <= ~b;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (6) @(posedge clk);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, a);
    nak = nak | a;
  endtask
  task automatic reg_write(input logic [6:0] adr, input logic [7:0] ptr, input logic [15:0] d);
    logic [7:0] x;
    nak = 1'b0;
    cond(1'b0, 1'b1, 1'b0);
    xfer({adr, 1'b0}, 1'b1, x);
    xfer(ptr, 1'b1, x);
    xfer(d[15:8], 1'b1, x);
    xfer(d[7:0], 1'b1, x);
    cond(1'b1, 1'b0, 1'b1);
  endtask
  task automatic reg_read(input logic [7:0] ptr);
    logic [7:0] m;
    logic [7:0] l;
    cond(1'b0, 1'b1, 1'b0);
    xfer({DEF_TARGET_ADDR, 1'b0}, 1'b1, m);
    xfer(ptr, 1'b1, m);
    cond(1'b0, 1'b1, 1'b0);
    xfer({DEF_TARGET_ADDR, 1'b1}, 1'b1, m);
    xfer(8'hff, 1'b0, m);
    xfer(8'hff, 1'b1, l);
    cond(1'b1, 1'b0, 1'b1);
    rd_word <= {m, l};
    rd_valid <= 1'b1;
    @(posedge clk);
    rd_valid <= 1'b0;
  endtask
endmodule

// ==== adc_alert_pkg.sv ====
/*
  constants for the converter result and window alert block:
  register pointers, field positions, reset values and bus encodings.
  assumes nothing of its users beyond a SystemVerilog package import.
*/
package adc_alert_pkg;
  // register pointer values (one byte on the serial bus)
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h02;
  localparam logic [7:0] PTR_UNDER  = 8'h03;
  localparam logic [7:0] PTR_OVER   = 8'h04;
  localparam logic [7:0] PTR_HYST   = 8'h05;

  // result word layout
  localparam int CONV_LSB  = 2;
  localparam int CONV_MSB  = 11;
  localparam int ALERT_BIT = 15;

  // configuration register bits
  localparam int CFG_FLAG_EN  = 0;
  localparam int CFG_PIN_EN   = 1;
  localparam int CFG_POL_HIGH = 2;

  // reset values
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [15:0] RST_UNDER  = 16'h0000;
  localparam logic [15:0] RST_OVER   = 16'h0ffc;
  localparam logic [15:0] RST_HYST   = 16'h0000;
  localparam logic [9:0]  RST_CONV   = 10'h000;

  // serial target default address
  localparam logic [6:0] DEF_TARGET_ADDR = 7'h54;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_PTR      = 4'b0011,
    ST_PTR_ACK  = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_WACK     = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RACK     = 4'b1000
  } bus_state_t;
endpackage

// ==== adc_alert_props.sv ====
/* port checker for the alert block.
   bound to every instance of the top module below. */
`timescale 1ns/1ps
module adc_alert_props (
  input wire logic       clk,        // clock
  input wire logic       reset_n,    // reset
  input wire logic       conv_valid, // new value
  input wire logic [9:0] conv_data,  // value
  input wire logic       scl_in,     // bus clock
  input wire logic       sda_in,     // bus data
  input wire logic       sda_out,    // drive level
  input wire logic       sda_oe,     // pull enable
  input wire logic       alert_pin   // alert
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] scl_hi;
  // high scl cycles; saturates so a long idle cannot wrap it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) scl_hi <= 4'h0;
    else if (!scl_in) scl_hi <= 4'h0;
    else if (scl_hi != 4'hf) scl_hi <= scl_hi + 4'h1;
  end
  sda_out_low_a: assert property (!sda_out)
    else $error("sda level high");
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("pull with scl high");
  oe_fall_low_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("release with scl high");
  oe_hold_a: assert property ($rose(scl_in) |=> $stable(sda_oe) [*3])
    else $error("sda moved in high phase");
  stop_free_a: assert property (scl_in && $rose(sda_in) |-> ##3 !sda_oe)
    else $error("sda held after stop");
  reset_quiet_a: assert property ($rose(reset_n) |-> !sda_oe [*3])
    else $error("sda pulled after reset");
  reset_pin_a: assert property ($rose(reset_n) |=> alert_pin)
    else $error("pin active after reset");
  pin_cause_a: assert property ($changed(alert_pin) && !$past(conv_valid, 2)
    |-> scl_hi < 4'h8)
    else $error("pin moved without cause");
endmodule
bind adc_result_window_alert adc_alert_props chk (.clk(clk), .reset_n(reset_n),
  .conv_valid(conv_valid), .conv_data(conv_data), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .alert_pin(alert_pin));

// ==== adc_result_window_alert.sv ====
/*
  result register, window comparator with hysteresis, alert pin and the
  serial register target through which the host reaches them.
  assumes conv_valid/conv_data come from logic on clk; scl and sda come
  from pins and are synchronised here; the sda wire is open drain.
*/
// Operation
// - latest conversion kept in read-only result word
// - ten-bit value sits in bits 2 to 11
// - bit 15 shows the alert flag
// - under-range limit register; below it raises alert
// - over-range limit register; above it raises alert
// - alert clears only beyond limit by hysteresis
// - flag enable, pin enable, selectable pin polarity
`timescale 1ns/1ps
module adc_result_window_alert
  import adc_alert_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = DEF_TARGET_ADDR
) (
  input  wire logic       clk,        // 40 MHz system clock
  input  wire logic       reset_n,    // asynchronous reset, active low
  input  wire logic       conv_valid, // one-cycle pulse: new conversion
  input  wire logic [9:0] conv_data,  // conversion value
  input  wire logic       scl_in,     // serial clock pin
  input  wire logic       sda_in,     // serial data pin level
  output logic            sda_out,    // serial data drive level (always low)
  output logic            sda_oe,     // high while pulling sda low
  output logic            alert_pin   // alert output pin
);

  // pulls the ten-bit value out of a word laid out like the result
  function automatic logic [9:0] field_of(input logic [15:0] w);
    field_of = w[CONV_MSB:CONV_LSB];
  endfunction

  logic [15:0] cfg;
  logic [15:0] under_range_limit;
  logic [15:0] over_range_limit;
  logic [15:0] hyst;
  logic [9:0]  conv;
  logic        under_alert;
  logic        over_alert;
  logic [2:0]  scl_sync;
  logic [2:0]  sda_sync;
  bus_state_t  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  tx_shift;
  logic [7:0]  pointer;
  logic        rw;
  logic        byte_idx;
  logic [7:0]  hold_msb;
  logic        wr_en;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic [15:0] result_word;
  logic        alert_flag;

  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond, sda_now;
  assign scl_rise   = scl_sync[1] & ~scl_sync[2];
  assign scl_fall   = ~scl_sync[1] & scl_sync[2];
  assign start_cond = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
  assign stop_cond  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
  assign sda_now    = sda_sync[1];

  // alert flag only reported when enabled
  assign alert_flag  = cfg[CFG_FLAG_EN] & (under_alert | over_alert);
  assign result_word = {alert_flag, 3'h0, conv, 2'h0};

  // read mux; unmapped pointers read zero
  always_comb begin
    case (pointer)
      PTR_RESULT: rd_word = result_word;
      PTR_CONFIG: rd_word = cfg;
      PTR_UNDER:  rd_word = under_range_limit;
      PTR_OVER:   rd_word = over_range_limit;
      PTR_HYST:   rd_word = hyst;
      default:    rd_word = 16'h0000;
    endcase
  end

  // each new conversion overwrites the stored one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) conv <= RST_CONV;
    else if (conv_valid) conv <= conv_data;
  end

  // window comparator; widened sums avoid wrap at the top of the range
  logic [10:0] low_plus_h, high_v, conv_plus_h;
  assign low_plus_h  = {1'b0, field_of(under_range_limit)} + {1'b0, field_of(hyst)};
  assign high_v      = {1'b0, field_of(over_range_limit)};
  assign conv_plus_h = {1'b0, conv_data} + {1'b0, field_of(hyst)};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      under_alert <= 1'b0;
      over_alert  <= 1'b0;
    end else if (conv_valid) begin
      if (conv_data < field_of(under_range_limit)) under_alert <= 1'b1;
      else if ({1'b0, conv_data} > low_plus_h) under_alert <= 1'b0;
      if (conv_data > field_of(over_range_limit)) over_alert <= 1'b1;
      else if (conv_plus_h < high_v) over_alert <= 1'b0;
    end
  end

  // pin: out of reset, inactive level is the opposite of the chosen polarity; reset drives it low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) alert_pin <= 1'b0;
    else alert_pin <= cfg[CFG_POL_HIGH] ~^
                      (cfg[CFG_PIN_EN] & (under_alert | over_alert));
  end

  // register writes; the result word is read-only and limits change
  // only through host writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg               <= RST_CONFIG;
      under_range_limit <= RST_UNDER;
      over_range_limit  <= RST_OVER;
      hyst              <= RST_HYST;
    end else if (wr_en) begin
      case (pointer)
        PTR_CONFIG: cfg <= wr_word;
        PTR_UNDER:  under_range_limit <= wr_word;
        PTR_OVER:   over_range_limit <= wr_word;
        PTR_HYST:   hyst <= wr_word;
        default:    ;
      endcase
    end
  end

  // serial target: address, pointer, then 16-bit words msb first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      pointer  <= PTR_RESULT;
      rw       <= 1'b0;
      byte_idx <= 1'b0;
      hold_msb <= 8'h00;
      wr_en    <= 1'b0;
      wr_word  <= 16'h0000;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (stop_cond) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        state   <= ST_ADDR; // also repeated start
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA: begin
            rx_shift <= {rx_shift[6:0], sda_now};
            bit_cnt  <= bit_cnt + 4'h1;
          end
          ST_RACK: if (sda_now) state <= ST_IDLE; // host nack ends the read
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: if (bit_cnt == BITS_PER_BYTE) begin
            if (rx_shift[7:1] == TARGET_ADDR) begin
              rw     <= rx_shift[0];
              sda_oe <= 1'b1;
              state  <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE; // not ours: stay off the wire
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt  <= 4'h0;
            byte_idx <= 1'b0;
            if (rw) begin
              tx_shift <= {rd_word[14:8], 1'b0};
              sda_oe   <= ~rd_word[15];
              hold_msb <= rd_word[7:0]; // low byte kept for a coherent word
              state    <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_PTR;
            end
          end
          ST_PTR: if (bit_cnt == BITS_PER_BYTE) begin
            pointer <= rx_shift;
            sda_oe  <= 1'b1;
            state   <= ST_PTR_ACK;
          end
          ST_WDATA: if (bit_cnt == BITS_PER_BYTE) begin
            sda_oe <= 1'b1;
            state  <= ST_WACK;
            if (!byte_idx) begin
              hold_msb <= rx_shift;
            end else begin
              wr_word <= {hold_msb, rx_shift};
              wr_en   <= 1'b1;
            end
            byte_idx <= ~byte_idx;
          end
          ST_PTR_ACK, ST_WACK: begin
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              sda_oe <= 1'b0; // release for the host acknowledge
              state  <= ST_RACK;
            end else begin
              sda_oe   <= ~tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            bit_cnt  <= 4'h0;
            byte_idx <= ~byte_idx;
            state    <= ST_RDATA;
            if (!byte_idx) begin
              sda_oe   <= ~hold_msb[7];
              tx_shift <= {hold_msb[6:0], 1'b0};
            end else begin
              sda_oe   <= ~rd_word[15];
              tx_shift <= {rd_word[14:8], 1'b0};
              hold_msb <= rd_word[7:0];
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ==== tb_top.sv ====
/* bench: host model on the bus, conversions driven here.
   needs the package, the checker and the host model. */
`timescale 1ns/1ps
module tb_top;
  import adc_alert_pkg::*;
  localparam int LO = 'h100, HI = 'h300, HY = 'h20;
  logic clk = 1'b0, reset_n = 1'b0, conv_valid = 1'b0;
  logic [9:0] conv_data = 10'h000;
  logic scl, pull, sda_oe, alert_pin, rd_valid, u_al, o_al;
  logic [15:0] rd_word;
  logic [15:0] exp_q[$];
  logic [9:0] tab[8] = '{10'h0ff, 10'h110, 10'h120, 10'h121, 10'h301, 10'h2e0, 10'h2df, 10'h300};
  int err_total = 0, num_checks = 0, seed = 60364;
  wire sda = !(pull || sda_oe); // pulled-up open-drain wire
  always #12.5 clk = ~clk;
  adc_result_window_alert dut (.clk(clk), .reset_n(reset_n), .conv_valid(conv_valid),
    .conv_data(conv_data), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .alert_pin(alert_pin));
  adc_alert_host host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull),
    .rd_valid(rd_valid), .rd_word(rd_word));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // each word read is matched against the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1)
      check("word", rd_word, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
  end
  task automatic rd(input logic [7:0] p, input logic [15:0] want);
    exp_q.push_back(want);
    host.reg_read(p);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    host.reg_write(DEF_TARGET_ADDR, p, d);
    check("ack", {15'h0, host.nak}, 16'h0000);
  endtask
  // model alert state, pulse one conversion, then check pin and result word
  task automatic convert(input logic [9:0] c);
    if (c < LO) u_al = 1'b1;
    else if (c > LO + HY) u_al = 1'b0;
    if (c > HI) o_al = 1'b1;
    else if (c + HY < HI) o_al = 1'b0;
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_data <= c;
    @(posedge clk);
    conv_valid <= 1'b0;
    repeat (2) @(posedge clk);
    check("pin", {15'h0, alert_pin}, {15'h0, u_al | o_al});
    rd(PTR_RESULT, {u_al | o_al, 3'h0, c, 2'h0});
  endtask
  initial begin
    u_al = 1'b0;
    o_al = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset pin", {15'h0, alert_pin}, 16'h0001);
    rd(PTR_RESULT, 16'h0000);
    rd(PTR_UNDER, RST_UNDER);
    rd(PTR_OVER, RST_OVER);
    rd(8'h07, 16'h0000);
    host.reg_write(7'h55, PTR_UNDER, 16'h1234);
    check("foreign nak", {15'h0, host.nak}, 16'h0001);
    wr(PTR_RESULT, 16'hffff);
    rd(PTR_RESULT, 16'h0000);
    $display("reset and access done");
    wr(PTR_UNDER, 16'(LO * 4));
    wr(PTR_OVER, 16'(HI * 4));
    wr(PTR_HYST, 16'(HY * 4));
    wr(PTR_CONFIG, 16'h0007);
    for (int i = 0; i < 16; i++) convert(i < 8 ? tab[i] : 10'($random(seed)));
    convert(10'h3ff);
    $display("window and hysteresis done");
    for (int k = 0; k < 8; k++) begin
      wr(PTR_CONFIG, 16'(k));
      repeat (2) @(posedge clk);
      check("pin cfg", {15'h0, alert_pin}, {15'h0, k[1] & o_al ^ !k[2]});
      rd(PTR_RESULT, {k[0] & o_al, 3'h0, 10'h3ff, 2'h0});
    end
    rd(PTR_UNDER, 16'(LO * 4));
    rd(PTR_OVER, 16'(HI * 4));
    rd(PTR_HYST, 16'(HY * 4));
    rd(PTR_CONFIG, 16'h0007);
    $display("config sweep done");
    complete_run();
  end
  // cuts a hang short
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule
